// [bench/test_core_exec_subset_inc_dec_branch.sv]
// test_core_exec_subset_inc_dec_branch: self-checking bench for ceb_exec
// assumes ceb_pkg compiled first; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_core_exec_subset_inc_dec_branch;
    import ceb_pkg::*;
    logic               clk = 1'h0;
    logic               rst_n = 1'h0;
    logic               cycleEn = 1'h0;
    logic [INSTR_W-1:0] instrWord = '0;
    logic [DATA_W-1:0]  fileRdData = '0;
    logic [7:0]         statusIn = '0;
    logic [FADDR_W-1:0] wrAddr;
    logic [FADDR_W-1:0] fileAddr;
    logic               fileWe;
    logic               zeroWe;
    logic               zeroVal;
    logic               flush;
    logic [DATA_W-1:0]  wrData;
    logic [DATA_W-1:0]  acc;
    logic [PC_W-1:0]    pc;
    logic [DATA_W-1:0]  accE;
    logic [PC_W-1:0]    pcE;
    int                 n_mismatch = 0;
    int                 checks_done = 0;
    int                 cycles = 0;

    ceb_exec u_dut (.clk(clk), .rst_n(rst_n), .cycleEn(cycleEn), .instrWord(instrWord),
        .fileAddr_r(fileAddr), .fileRdData(fileRdData), .statusIn(statusIn), .fileWe_r(fileWe),
        .fileWrAddr_r(wrAddr), .fileWrData_r(wrData), .acc_r(acc), .zeroWe_r(zeroWe),
        .zeroVal_r(zeroVal), .pc_r(pc), .flush_r(flush));

    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 600)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one instruction cycle, called and returning on a falling edge
    task automatic issue(input logic [11:0] w, input logic [7:0] f);
        cycleEn = 1'h1;
        instrWord = w;
        fileRdData = f;
        @(negedge clk);
        pcE = pcE + 11'h1;
    endtask

    // word after a jump or skip, discarded when sk is set
    task automatic follow(input logic sk);
        issue({OPC_OR_LIT, 8'hFF}, 8'h00);
        if (!sk) accE = 8'hFF;
        chk(acc, accE);
        chk({flush, zeroWe}, {1'h0, !sk});
        chk(pc, pcE);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_file_ops();
        logic [5:0] opc [3] = '{OPC_COMPLEMENT, OPC_DECREMENT, OPC_INCREMENT};
        logic [7:0] vals [3] = '{8'h00, 8'h01, 8'hFF};
        logic [7:0] res;
        logic [4:0] fa;
        for (int o = 0; o < 3; o++)
            for (int v = 0; v < 3; v++)
                for (int d = 0; d < 2; d++)
                begin
                    fa = 5'h0A + 5'(v);
                    issue({opc[o], d[0], fa}, vals[v]);
                    res = (o == 0) ? ~vals[v] : (o == 1) ? vals[v] - 8'h1 : vals[v] + 8'h1;
                    if (d == 0) accE = res;
                    chk(acc, accE);
                    chk(fileWe, d[0]);
                    chk(fileAddr, fa);
                    if (d == 1) chk({wrAddr, wrData}, {fa, res});
                    chk({zeroWe, zeroVal}, {1'h1, res == 8'h00});
                    chk({flush, pc}, {1'h0, pcE});
                end
    endtask

    task automatic t_skip();
        logic [7:0] vals [4] = '{8'h01, 8'h02, 8'hFF, 8'hFE};
        logic [7:0] res;
        for (int v = 0; v < 4; v++)
        begin
            res = (v < 2) ? vals[v] - 8'h1 : vals[v] + 8'h1;
            issue({(v < 2) ? OPC_DEC_SKIP : OPC_INC_SKIP, v[0], 5'h11}, vals[v]);
            if (!v[0]) accE = res;
            chk(acc, accE);
            chk({fileWe, zeroWe}, {v[0], 1'h0});
            if (v[0]) chk(wrData, res);
            chk(fileAddr, 5'h11);
            chk(flush, res == 8'h00);
            follow(res == 8'h00);
        end
    endtask

    task automatic t_jump();
        for (int p = 0; p < 4; p++)
        begin
            statusIn = {~p[0], p[1:0], 5'h15};
            issue({OPC_JUMP, p[0], 8'h3C}, 8'h00);
            pcE = {p[1:0], p[0], 8'h3C};
            chk(pc, pcE);
            chk({flush, zeroWe, fileWe}, 3'h4);
            follow(1'h1);
        end
    endtask

    task automatic t_or_lit();
        logic [7:0] lits [4] = '{8'h00, 8'h00, 8'h5A, 8'hA5};
        issue({OPC_COMPLEMENT, 1'h0, 5'h03}, 8'hFF);
        accE = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            issue({OPC_OR_LIT, lits[i]}, 8'hFF);
            accE = accE | lits[i];
            chk(acc, accE);
            chk({zeroWe, zeroVal, fileWe}, {1'h1, accE == 8'h00, 1'h0});
        end
    endtask

    initial
    begin
        accE = ACC_RST;
        pcE = PC_RST;
        repeat (16) @(negedge clk);
        chk({acc, 5'h00, pc}, {accE, 5'h00, pcE});
        rst_n = 1'h1;
        t_file_ops();
        t_skip();
        t_jump();
        t_or_lit();
        wrap_up();
    end
endmodule
`default_nettype wire

// [rtl/ceb_exec.sv]
// ceb_exec: executes a subset of 8-bit core instructions, one per enabled cycle
// assumes fetch supplies the word each instruction cycle and file reads are combinational
//
// Contract
// - complement file register, result to acc or file by d, update zero
// - decrement file register, result to acc or file by d, update zero
// - increment file register, result to acc or file by d, update zero
// - decrement and skip: write result, flags untouched, zero result flushes prefetch
// - increment and skip: write result, flags untouched, zero result flushes prefetch
// - jump loads 9-bit immediate into pc low, status 6:5 into pc 10:9
// - jump always two cycles, prefetch discarded, no flag change
// - or literal into accumulator, update zero
`timescale 1ns/10ps
`default_nettype none
module ceb_exec
    import ceb_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // instruction side
    input  wire logic               cycleEn,
    input  wire logic [INSTR_W-1:0] instrWord,
    // file register read
    output logic      [FADDR_W-1:0] fileAddr_r,
    input  wire logic [DATA_W-1:0]  fileRdData,
    input  wire logic [7:0]         statusIn,
    // file register write
    output logic                    fileWe_r,
    output logic      [FADDR_W-1:0] fileWrAddr_r,
    output logic      [DATA_W-1:0]  fileWrData_r,
    // core state
    output logic      [DATA_W-1:0]  acc_r,
    output logic                    zeroWe_r,
    output logic                    zeroVal_r,
    output logic      [PC_W-1:0]    pc_r,
    output logic                    flush_r
);

    // ----------------------------------------
    // operand decode
    // ----------------------------------------
    function automatic logic isFileOp(input logic [INSTR_W-1:0] w, input logic [5:0] opc);
        isFileOp = (w[11:6] == opc);
    endfunction

    logic [DATA_W-1:0] result;
    logic              toFile;
    logic              doWrite;
    logic              setZero;
    logic              skipHit;
    logic              isJump;

    always_comb
    begin
        result  = '0;
        toFile  = instrWord[DEST_BIT];
        doWrite = 1'b0;
        setZero = 1'b0;
        skipHit = 1'b0;
        isJump  = 1'b0;
        if (isFileOp(instrWord, OPC_COMPLEMENT))
        begin
            result  = ~fileRdData;
            doWrite = 1'b1;
            setZero = 1'b1;
        end
        else if (isFileOp(instrWord, OPC_DECREMENT))
        begin
            result  = fileRdData - 8'h01;
            doWrite = 1'b1;
            setZero = 1'b1;
        end
        else if (isFileOp(instrWord, OPC_INCREMENT))
        begin
            result  = fileRdData + 8'h01;
            doWrite = 1'b1;
            setZero = 1'b1;
        end
        else if (isFileOp(instrWord, OPC_DEC_SKIP))
        begin
            result  = fileRdData - 8'h01;
            doWrite = 1'b1;
            skipHit = (result == 8'h00);
        end
        else if (isFileOp(instrWord, OPC_INC_SKIP))
        begin
            result  = fileRdData + 8'h01;
            doWrite = 1'b1;
            skipHit = (result == 8'h00);
        end
        else if (instrWord[11:9] == OPC_JUMP)
        begin
            isJump = 1'b1;
        end
        else if (instrWord[11:8] == OPC_OR_LIT)
        begin
            result  = acc_r | instrWord[7:0];
            doWrite = 1'b1;
            toFile  = 1'b0;
            setZero = 1'b1;
        end
    end

    // ----------------------------------------
    // execute state
    // ----------------------------------------
    ceb_state_type     state_r;
    ceb_state_type     state_nxt;
    logic [DATA_W-1:0] acc_nxt;
    logic [PC_W-1:0]   pc_nxt;
    logic              fileWe_nxt;
    logic [DATA_W-1:0] fileWrData_nxt;
    logic              zeroWe_nxt;
    logic              zeroVal_nxt;
    logic              flush_nxt;

    always_comb
    begin
        state_nxt      = state_r;
        acc_nxt        = acc_r;
        pc_nxt         = pc_r;
        fileWe_nxt     = 1'b0;
        fileWrData_nxt = fileWrData_r;
        zeroWe_nxt     = 1'b0;
        zeroVal_nxt    = zeroVal_r;
        flush_nxt      = 1'b0;
        if (cycleEn)
        begin
            pc_nxt = pc_r + 11'h001;
            case (state_r)
                EX_FLUSH:
                begin
                    // prefetched word runs as a no-operation
                    state_nxt = EX_RUN;
                end
                default:
                begin
                    if (doWrite && toFile)
                    begin
                        fileWe_nxt     = 1'b1;
                        fileWrData_nxt = result;
                    end
                    else if (doWrite)
                    begin
                        acc_nxt = result;
                    end
                    if (setZero)
                    begin
                        zeroWe_nxt  = 1'b1;
                        zeroVal_nxt = (result == 8'h00);
                    end
                    if (isJump)
                    begin
                        pc_nxt = {statusIn[PAGE_HI:PAGE_LO], instrWord[JUMP_W-1:0]};
                    end
                    if (isJump || skipHit)
                    begin
                        state_nxt = EX_FLUSH;
                        flush_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r      <= EX_RUN;
            acc_r        <= ACC_RST;
            pc_r         <= PC_RST;
            fileWe_r     <= 1'b0;
            fileWrData_r <= '0;
            fileWrAddr_r <= '0;
            fileAddr_r   <= '0;
            zeroWe_r     <= 1'b0;
            zeroVal_r    <= 1'b0;
            flush_r      <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            acc_r        <= acc_nxt;
            pc_r         <= pc_nxt;
            fileWe_r     <= fileWe_nxt;
            fileWrData_r <= fileWrData_nxt;
            fileWrAddr_r <= instrWord[FADDR_W-1:0];
            fileAddr_r   <= instrWord[FADDR_W-1:0];
            zeroWe_r     <= zeroWe_nxt;
            zeroVal_r    <= zeroVal_nxt;
            flush_r      <= flush_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_comp_result: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && isFileOp(instrWord, OPC_COMPLEMENT) && !instrWord[DEST_BIT]
        |=> acc_r == ~$past(fileRdData))
        else $error("complement result wrong");
    chk_dec_result: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && isFileOp(instrWord, OPC_DECREMENT) && instrWord[DEST_BIT]
        |=> fileWe_r && fileWrData_r == $past(fileRdData) - 8'h01)
        else $error("decrement write wrong");
    chk_inc_result: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && isFileOp(instrWord, OPC_INCREMENT) && !instrWord[DEST_BIT]
        |=> acc_r == $past(fileRdData) + 8'h01 && zeroWe_r)
        else $error("increment result wrong");
    chk_decskip_flush: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && isFileOp(instrWord, OPC_DEC_SKIP)
        |=> !zeroWe_r && (flush_r == ($past(fileRdData) == 8'h01)))
        else $error("decrement skip wrong");
    chk_incskip_flush: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && isFileOp(instrWord, OPC_INC_SKIP)
        |=> !zeroWe_r && (flush_r == ($past(fileRdData) == 8'hFF)))
        else $error("increment skip wrong");
    chk_jump_target: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && instrWord[11:9] == OPC_JUMP
        |=> pc_r == {$past(statusIn[6:5]), $past(instrWord[8:0])})
        else $error("jump target wrong");
    chk_jump_flush: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && instrWord[11:9] == OPC_JUMP
        |=> flush_r && !zeroWe_r && state_r == EX_FLUSH)
        else $error("jump not two cycles");
    chk_or_zero: assert property (@(posedge clk) disable iff (!rst_n)
        cycleEn && state_r == EX_RUN && instrWord[11:8] == OPC_OR_LIT
        |=> acc_r == ($past(acc_r) | $past(instrWord[7:0])) && zeroWe_r
            && zeroVal_r == (acc_r == 8'h00))
        else $error("or literal wrong");

endmodule
`default_nettype wire

// [rtl/ceb_pkg.sv]
// ceb_pkg: constants for the execution subset block
// assumes a 12-bit instruction word and an 11-bit program counter
package ceb_pkg;
    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 5;
    localparam int PC_W     = 11;
    localparam int INSTR_W  = 12;
    // opcode patterns, 12-bit word
    localparam logic [5:0]  OPC_COMPLEMENT = 6'h09; // 0010 01df ffff
    localparam logic [5:0]  OPC_DECREMENT  = 6'h03; // 0000 11df ffff
    localparam logic [5:0]  OPC_INCREMENT  = 6'h0A; // 0010 10df ffff
    localparam logic [5:0]  OPC_DEC_SKIP   = 6'h0B; // 0010 11df ffff
    localparam logic [5:0]  OPC_INC_SKIP   = 6'h0F; // 0011 11df ffff
    localparam logic [2:0]  OPC_JUMP       = 3'h5;  // 101k kkkk kkkk
    localparam logic [3:0]  OPC_OR_LIT     = 4'hD;  // 1101 kkkk kkkk
    // field positions
    localparam int DEST_BIT  = 5;
    localparam int PAGE_LO   = 5;
    localparam int PAGE_HI   = 6;
    localparam int JUMP_W    = 9;
    // reset values
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [10:0] PC_RST  = 11'h7FF;
    typedef enum logic [1:0] {
        EX_RUN   = 2'b00,
        EX_FLUSH = 2'b01
    } ceb_state_type;
endpackage
